// [hw/ldics_cmd_slave.v]
// Two-wire write-only slave and command decoder for a segment LCD driver
//
// What this block does
// - SDA falling while SCL high is a START.
// - SDA rising while SCL high is a STOP; bus returns idle.
// - Ninth clock after each byte is acknowledge; acknowledger pulls SDA low.
// - Write-only receiver; drives SDA only to acknowledge; ignores reads.
// - Accept address 0111000x/0111001x write only, bit 1 equal to strap.
// - Matching devices acknowledge address; others ignore until next START.
// - Command bit 7 set means another command follows, clear means data.
// - Mode set: enable bit 3, bias bit 2, drive mode bits 1:0.
// - Bank select: bit 1 picks the RAM bank receiving data; ignored in 1:3 or 1:4.
// - Blink: bits 1:0 set the blink rate.
// - Blink bit 2 picks alternate-bank blinking; not in 1:3 or 1:4.
// - Every addressed device acknowledges every command byte.
// - Data byte stored at pointer and subaddress; pointer then advances, subaddress only when pointer wraps.
// - Data byte acknowledged only when subaddress counter matches pins.
// - Repeated START begins a new access.
// - Pointer steps 8 static, 4 for 1:2, 3 for 1:3, 2 for 1:4.
// - Store only while held subaddress equals strapped subaddress.
// - Drive mode codes: static 01, 1:2 10, 1:3 11, 1:4 00.
// - Blink codes: 00 off; 01, 10, 11 divide display clock.
`timescale 1ns/1ns
`include "ldics_regs.vh"

module ldics_cmd_slave (
  input wire clk_sys,
  input wire rst,
  input wire sclPin,
  input wire sdaIn,
  input wire addrStrapPin,
  input wire subaddrPin0,
  input wire subaddrPin1,
  input wire subaddrPin2,
  output wire sdaOut,
  output wire sdaOeN,
  output wire displayEnable,
  output wire biasSelect,
  output wire driveModeHi,
  output wire driveModeLo,
  output wire [5:0] dataPointer,
  output wire [2:0] subaddrCount,
  output wire inputBank,
  output wire outputBank,
  output wire blinkRateHi,
  output wire blinkRateLo,
  output wire blinkAltBank,
  output wire ramWrEn,
  output wire [5:0] ramWrAddr,
  output wire [7:0] ramWrData,
  output wire ramWrBank,
  output wire busActive
);

  // Transfer phases, one-hot
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_CMD = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;
  wire [5:0] syncBus;
  wire sclS, sdaS, strapS;
  wire [2:0] subPinS;
  reg sclPrev_reg, sdaPrev_reg, busy_reg;
  reg [4:0] state_reg, state_next;
  reg [3:0] bitCnt_reg, bitCnt_next;
  reg [7:0] shift_reg, shift_next;
  reg ackPhase_reg, ackPhase_next;
  reg oeN_reg, oeN_next;
  reg enable_reg, enable_next;
  reg bias_reg, bias_next;
  reg [1:0] mode_reg, mode_next;
  reg [5:0] ptr_reg, ptr_next;
  reg [2:0] sub_reg, sub_next;
  reg inBank_reg, inBank_next;
  reg outBank_reg, outBank_next;
  reg [1:0] blink_reg, blink_next;
  reg alt_reg, alt_next;
  reg wrEn_reg, wrEn_next;
  reg [5:0] wrAddr_reg, wrAddr_next;
  reg [7:0] wrData_reg, wrData_next;
  reg wrBank_reg, wrBank_next;
  wire startSeen, stopSeen, sclRise, sclFall;
  wire receiving, byteFull, subMatch;
  wire [8:0] advanced;

  // Drive modes that own an alternate RAM bank
  function bankable;
    input [1:0] mode;
    begin
      bankable = (mode == `LDICS_MODE_STATIC) || (mode == `LDICS_MODE_MUX2);
    end
  endfunction

  // Next {subaddress, pointer} after one data byte
  function [8:0] ptrAdvance;
    input [5:0] ptr;
    input [2:0] sub;
    input [1:0] mode;
    reg [5:0] step;
    reg [6:0] sum;
    begin
      step = `LDICS_STEP_MUX4;
      sum = 7'h00;
      case (mode)
        `LDICS_MODE_STATIC: step = `LDICS_STEP_STATIC;
        `LDICS_MODE_MUX2: step = `LDICS_STEP_MUX2;
        `LDICS_MODE_MUX3: step = `LDICS_STEP_MUX3;
        default: step = `LDICS_STEP_MUX4;
      endcase
      sum = {1'b0, ptr} + {1'b0, step};
      // Past the last location, loading carries on at the next subaddress
      if (sum > {1'b0, `LDICS_PTR_LAST})
        ptrAdvance = {sub + `LDICS_SUB_ONE, `LDICS_PTR_ZERO};
      else
        ptrAdvance = {sub, sum[5:0]};
    end
  endfunction
  // Pins pass two flip-flops before any logic reads them
  ldics_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn({sclPin, sdaIn, addrStrapPin, subaddrPin2, subaddrPin1, subaddrPin0}),
    .syncOut(syncBus)
  );

  assign sclS = syncBus[5];
  assign sdaS = syncBus[4];
  assign strapS = syncBus[3];
  assign subPinS = syncBus[2:0];

  // Bus condition and edge detection on the synchronised lines
  assign startSeen = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
  assign stopSeen = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
  assign sclRise = sclS && !sclPrev_reg;
  assign sclFall = !sclS && sclPrev_reg;
  assign receiving = (state_reg == ST_ADDR) || (state_reg == ST_CMD) || (state_reg == ST_DATA);
  assign byteFull = (bitCnt_reg == `LDICS_BITS_PER_BYTE);
  assign subMatch = (sub_reg == subPinS);
  assign advanced = ptrAdvance(ptr_reg, sub_reg, mode_reg);

  // Next-state logic for the receiver and command decoder
  always @*
  begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    ackPhase_next = ackPhase_reg;
    oeN_next = oeN_reg;
    enable_next = enable_reg;
    bias_next = bias_reg;
    mode_next = mode_reg;
    ptr_next = ptr_reg;
    sub_next = sub_reg;
    inBank_next = inBank_reg;
    outBank_next = outBank_reg;
    blink_next = blink_reg;
    alt_next = alt_reg;
    wrEn_next = 1'b0;
    wrAddr_next = wrAddr_reg;
    wrData_next = wrData_reg;
    wrBank_next = wrBank_reg;
    if (startSeen)
    begin
      // Any START, repeated or not, opens a new access
      state_next = ST_ADDR;
      bitCnt_next = `LDICS_BITCNT_ZERO;
      ackPhase_next = 1'b0;
      oeN_next = 1'b1;
    end
    else if (stopSeen)
    begin
      // A partial byte is dropped; configuration stays as it was
      state_next = ST_IDLE;
      bitCnt_next = `LDICS_BITCNT_ZERO;
      ackPhase_next = 1'b0;
      oeN_next = 1'b1;
    end
    else if (sclRise && receiving && !ackPhase_reg && !byteFull)
    begin
      // Sample SDA once per SCL high phase
      shift_next = {shift_reg[6:0], sdaS};
      bitCnt_next = bitCnt_reg + `LDICS_BITCNT_ONE;
    end
    else if (sclFall && ackPhase_reg)
    begin
      // End of the acknowledge clock: release SDA, next byte follows
      ackPhase_next = 1'b0;
      oeN_next = 1'b1;
      bitCnt_next = `LDICS_BITCNT_ZERO;
    end
    else if (sclFall && receiving && byteFull)
    begin
      ackPhase_next = 1'b1;
      case (state_reg)
        ST_ADDR:
        begin
          if ((shift_reg[7:2] == `LDICS_ADDR_PREFIX) && (shift_reg[1] == strapS) &&
              (shift_reg[0] == `LDICS_RW_WRITE))
          begin
            oeN_next = 1'b0;
            state_next = ST_CMD;
          end
          else
            state_next = ST_SKIP;
        end
        ST_CMD:
        begin
          oeN_next = 1'b0;
          if (!shift_reg[`LDICS_CONT_BIT])
            state_next = ST_DATA;
          casez (shift_reg[6:0])
            `LDICS_OP_LOAD_PTR: ptr_next = shift_reg[5:0];
            `LDICS_OP_MODE_SET:
            begin
              enable_next = shift_reg[`LDICS_E_BIT];
              bias_next = shift_reg[`LDICS_B_BIT];
              mode_next = shift_reg[1:0];
            end
            `LDICS_OP_DEV_SEL: sub_next = shift_reg[2:0];
            `LDICS_OP_BLINK:
            begin
              blink_next = shift_reg[1:0];
              alt_next = shift_reg[`LDICS_ALT_BLINK_BIT] && bankable(mode_reg);
            end
            `LDICS_OP_BANK_SEL:
            begin
              if (bankable(mode_reg))
              begin
                inBank_next = shift_reg[`LDICS_IN_BANK_BIT];
                outBank_next = shift_reg[`LDICS_OUT_BANK_BIT];
              end
            end
            default: state_next = state_next;
          endcase
        end
        ST_DATA:
        begin
          // All devices track the pointer; only the selected one stores
          if (subMatch)
          begin
            oeN_next = 1'b0;
            wrEn_next = 1'b1;
            wrAddr_next = ptr_reg;
            wrData_next = shift_reg;
            wrBank_next = inBank_reg;
          end
          sub_next = advanced[8:6];
          ptr_next = advanced[5:0];
        end
        default: ackPhase_next = 1'b0;
      endcase
    end
  end

  // State registers
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bitCnt_reg <= `LDICS_BITCNT_ZERO;
      shift_reg <= 8'h00;
      ackPhase_reg <= 1'b0;
      oeN_reg <= 1'b1;
      enable_reg <= `LDICS_RST_ENABLE;
      bias_reg <= `LDICS_RST_BIAS;
      mode_reg <= `LDICS_RST_MODE;
      ptr_reg <= `LDICS_RST_PTR;
      sub_reg <= `LDICS_RST_SUB;
      inBank_reg <= `LDICS_RST_BANK;
      outBank_reg <= `LDICS_RST_BANK;
      blink_reg <= `LDICS_RST_BLINK;
      alt_reg <= 1'b0;
      wrEn_reg <= 1'b0;
      wrAddr_reg <= `LDICS_RST_PTR;
      wrData_reg <= 8'h00;
      wrBank_reg <= `LDICS_RST_BANK;
      busy_reg <= 1'b0;
    end
    else
    begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      ackPhase_reg <= ackPhase_next;
      oeN_reg <= oeN_next;
      enable_reg <= enable_next;
      bias_reg <= bias_next;
      mode_reg <= mode_next;
      ptr_reg <= ptr_next;
      sub_reg <= sub_next;
      inBank_reg <= inBank_next;
      outBank_reg <= outBank_next;
      blink_reg <= blink_next;
      alt_reg <= alt_next;
      wrEn_reg <= wrEn_next;
      wrAddr_reg <= wrAddr_next;
      wrData_reg <= wrData_next;
      wrBank_reg <= wrBank_next;
      busy_reg <= (state_next != ST_IDLE);
    end
  end

  // Outputs straight from flip-flops except sdaOut, tied to 0; SDA is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOeN = oeN_reg;
  assign displayEnable = enable_reg;
  assign biasSelect = bias_reg;
  assign driveModeHi = mode_reg[1];
  assign driveModeLo = mode_reg[0];
  assign dataPointer = ptr_reg;
  assign subaddrCount = sub_reg;
  assign inputBank = inBank_reg;
  assign outputBank = outBank_reg;
  assign blinkRateHi = blink_reg[1];
  assign blinkRateLo = blink_reg[0];
  assign blinkAltBank = alt_reg;
  assign ramWrEn = wrEn_reg;
  assign ramWrAddr = wrAddr_reg;
  assign ramWrData = wrData_reg;
  assign ramWrBank = wrBank_reg;
  assign busActive = busy_reg;

endmodule

// [hw/ldics_regs.vh]
// Constants for the LCD driver two-wire command slave
`ifndef LDICS_REGS_VH
`define LDICS_REGS_VH

// Slave address: upper six bits fixed, bit 1 strapped, bit 0 is read/write
`define LDICS_ADDR_PREFIX 6'h1C
`define LDICS_RW_WRITE 1'h0

// Bits per byte and bit-counter width helpers
`define LDICS_BITS_PER_BYTE 4'h8
`define LDICS_BITCNT_ZERO 4'h0
`define LDICS_BITCNT_ONE 4'h1

// Command byte fields
`define LDICS_CONT_BIT 7
`define LDICS_E_BIT 3
`define LDICS_B_BIT 2
`define LDICS_IN_BANK_BIT 1
`define LDICS_OUT_BANK_BIT 0
`define LDICS_ALT_BLINK_BIT 2

// Opcode patterns on bits 6..0, z marks don't care
`define LDICS_OP_MODE_SET 7'b10?????
`define LDICS_OP_LOAD_PTR 7'b0??????
`define LDICS_OP_DEV_SEL 7'b1100???
`define LDICS_OP_BLINK 7'b1110???
`define LDICS_OP_BANK_SEL 7'b11110??

// Drive mode encoding
`define LDICS_MODE_STATIC 2'h1
`define LDICS_MODE_MUX2 2'h2
`define LDICS_MODE_MUX3 2'h3
`define LDICS_MODE_MUX4 2'h0

// Data pointer step per stored byte, per drive mode
`define LDICS_STEP_STATIC 6'h08
`define LDICS_STEP_MUX2 6'h04
`define LDICS_STEP_MUX3 6'h03
`define LDICS_STEP_MUX4 6'h02

// Highest data pointer value before wrapping to the next subaddress
`define LDICS_PTR_LAST 6'h27
`define LDICS_PTR_ZERO 6'h00
`define LDICS_SUB_ONE 3'h1

// Blink rate encoding; nonzero codes divide the display clock
`define LDICS_BLINK_OFF 2'h0
`define LDICS_BLINK_DIV1 768
`define LDICS_BLINK_DIV2 1536
`define LDICS_BLINK_DIV3 3072

// Reset values of the configuration state
`define LDICS_RST_MODE 2'h1
`define LDICS_RST_ENABLE 1'h0
`define LDICS_RST_BIAS 1'h0
`define LDICS_RST_BANK 1'h0
`define LDICS_RST_BLINK 2'h0
`define LDICS_RST_PTR 6'h00
`define LDICS_RST_SUB 3'h0

`endif

// [hw/ldics_sync.v]
// Two-flop synchroniser for the bus and strap pins
`timescale 1ns/1ns
module ldics_sync #(
  parameter WIDTH = 6
) (
  input wire clk_sys,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second stage
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stage1_reg <= {WIDTH{1'b1}};
      stage2_reg <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule

// [testbench/ldics_bus_master.sv]
// Bus master model driving the two-wire clock and data lines
`timescale 1ns/1ns
module ldics_bus_master (
  input logic clk_sys,
  input logic sdaLine,
  output logic sclPin,
  output logic sdaDrv
);
  // Idle bus: both lines released high
  initial
  begin
    sclPin = 1'h1;
    sdaDrv = 1'h1;
  end
  // Half a bus clock period, changes land on falling system edges
  task automatic half;
    repeat (8) @(negedge clk_sys);
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic startCond;
    repeat (2) @(negedge clk_sys);
    sdaDrv = 1'h1;
    half;
    sclPin = 1'h1;
    half;
    sdaDrv = 1'h0;
    half;
    sclPin = 1'h0;
  endtask
  // Stop: data rises while clock is high
  task automatic stopCond;
    repeat (2) @(negedge clk_sys);
    sdaDrv = 1'h0;
    half;
    sclPin = 1'h1;
    half;
    sdaDrv = 1'h1;
    half;
  endtask
  // MSB first, data moved only while clock is low; ninth clock samples ack
  task automatic sendBits(input logic [7:0] b, input int n, output logic ack);
    ack = 1'h0;
    for (int i = 7; i > 7 - n; i--)
    begin
      repeat (2) @(negedge clk_sys);
      sdaDrv = b[i];
      half;
      sclPin = 1'h1;
      half;
      sclPin = 1'h0;
    end
    if (n == 8)
    begin
      repeat (2) @(negedge clk_sys);
      sdaDrv = 1'h1;
      half;
      sclPin = 1'h1;
      repeat (4) @(negedge clk_sys);
      ack = !sdaLine;
      repeat (4) @(negedge clk_sys);
      sclPin = 1'h0;
    end
  endtask
endmodule

// [testbench/ldics_props.sv]
// Concurrent checks on the ports of the two-wire command slave
`timescale 1ns/1ns
module ldics_props (
  input logic clk_sys,
  input logic rst,
  input logic sclPin,
  input logic sdaIn,
  input logic subaddrPin0,
  input logic subaddrPin1,
  input logic subaddrPin2,
  input logic sdaOeN,
  input logic displayEnable,
  input logic biasSelect,
  input logic driveModeHi,
  input logic driveModeLo,
  input logic [5:0] dataPointer,
  input logic [2:0] subaddrCount,
  input logic inputBank,
  input logic outputBank,
  input logic blinkRateHi,
  input logic blinkRateLo,
  input logic ramWrEn,
  input logic [5:0] ramWrAddr,
  input logic busActive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Expected pointer after a stored byte, wrapping past the last address
  wire [1:0] md = {driveModeHi, driveModeLo};
  wire [5:0] stepVal = md == 2'h1 ? 6'h08 : md == 2'h2 ? 6'h04 : md == 2'h3 ? 6'h03 : 6'h02;
  wire [6:0] sumPtr = {1'h0, ramWrAddr} + {1'h0, stepVal};
  wire [5:0] nextPtr = sumPtr > 7'h27 ? 6'h00 : sumPtr[5:0];
  wire [7:0] cfg = {displayEnable, biasSelect, md, inputBank, outputBank, blinkRateHi,
    blinkRateLo};

  start_open_a: assert property (
    sclPin && $past(sclPin) && $fell(sdaIn) |-> ##[2:6] busActive)
    else $error("start did not open a transfer");
  stop_idle_a: assert property (
    sclPin && $past(sclPin) && $rose(sdaIn) |-> ##[2:6] !busActive)
    else $error("stop did not return to idle");
  idle_quiet_a: assert property (!busActive |-> sdaOeN)
    else $error("data line pulled while idle");
  ack_begin_a: assert property ($fell(sdaOeN) |-> !sclPin ##0 !sdaOeN [*8])
    else $error("acknowledge not held through its clock");
  // Pointer wrap moves the subaddress in every device, acknowledged or not
  cfg_on_ack_a: assert property (
    !$stable(cfg) || (!$stable(subaddrCount) && $stable(dataPointer)) |-> !sdaOeN)
    else $error("configuration changed outside an acknowledge");
  wr_pulse_a: assert property (ramWrEn |=> !ramWrEn)
    else $error("write strobe longer than one cycle");
  wr_acked_a: assert property (ramWrEn |-> !sdaOeN)
    else $error("stored byte not acknowledged");
  wr_sub_a: assert property (
    ramWrEn |-> $past(subaddrCount) == {subaddrPin2, subaddrPin1, subaddrPin0})
    else $error("byte stored with subaddress mismatch");
  wr_addr_a: assert property (ramWrEn |-> ramWrAddr == $past(dataPointer))
    else $error("store address differs from pointer");
  ptr_step_a: assert property (ramWrEn |-> ##[0:2] dataPointer == nextPtr)
    else $error("pointer step wrong for drive mode");
endmodule

bind ldics_cmd_slave ldics_props ldics_props_inst (.clk_sys, .rst, .sclPin, .sdaIn,
  .subaddrPin0, .subaddrPin1, .subaddrPin2, .sdaOeN, .displayEnable, .biasSelect,
  .driveModeHi, .driveModeLo, .dataPointer, .subaddrCount, .inputBank, .outputBank,
  .blinkRateHi, .blinkRateLo, .ramWrEn, .ramWrAddr, .busActive);

// [testbench/tb.sv]
// Self-checking testbench for the two-wire command slave
`timescale 1ns/1ns
module tb;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic strap = 1'h0;
  logic [2:0] subPins = 3'h2;
  logic [7:0] wrCount = 8'h00;
  int errors = 0;
  int checksDone = 0;
  int cycles = 0;
  logic sclPin, sdaDrv, sdaOut, sdaOeN, a;
  logic displayEnable, biasSelect, driveModeHi, driveModeLo, inputBank, outputBank;
  logic blinkRateHi, blinkRateLo, blinkAltBank, ramWrEn, ramWrBank, busActive;
  logic [5:0] dataPointer, ramWrAddr;
  logic [2:0] subaddrCount;
  logic [7:0] ramWrData;
  logic [5:0] stepTab [4] = '{6'h08, 6'h04, 6'h03, 6'h02};
  // Open-drain data line with pull-up
  wire sdaLine = sdaDrv & (sdaOeN | sdaOut);
  wire [7:0] cfg = {displayEnable, biasSelect, driveModeHi, driveModeLo, inputBank, outputBank,
    blinkRateHi, blinkRateLo};

  ldics_bus_master mst (.clk_sys, .sdaLine, .sclPin, .sdaDrv);
  ldics_cmd_slave ldics_cmd_slave_inst (.clk_sys, .rst, .sclPin, .sdaIn(sdaLine),
    .addrStrapPin(strap), .subaddrPin0(subPins[0]), .subaddrPin1(subPins[1]),
    .subaddrPin2(subPins[2]), .sdaOut, .sdaOeN, .displayEnable, .biasSelect, .driveModeHi,
    .driveModeLo, .dataPointer, .subaddrCount, .inputBank, .outputBank, .blinkRateHi,
    .blinkRateLo, .blinkAltBank, .ramWrEn, .ramWrAddr, .ramWrData, .ramWrBank, .busActive);

  // Clock, store counter and cycle ceiling
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (ramWrEn === 1'h1)
      wrCount <= wrCount + 8'h01;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors++;
      stop_test;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // One byte and its acknowledge
  task automatic put(input logic [7:0] b, input logic e);
    mst.sendBits(b, 8, a);
    chk("ack", {7'h0, e}, {7'h0, a});
  endtask
  task automatic open(input logic [7:0] adr, input logic e);
    mst.startCond;
    put(adr, e);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst = 1'h0;
    repeat (4) @(negedge clk_sys);
    chk("cfg", 8'h10, cfg);
    chk("idle", 8'h02, {1'h0, subaddrCount, busActive, ramWrEn, sdaOeN, sdaOut});
    open(8'h72, 1'h0);
    put(8'h49, 1'h0);
    open(8'h71, 1'h0);
    mst.stopCond;
    chk("cfg", 8'h10, cfg);
    open(8'h70, 1'h1);
    put(8'hC9, 1'h1);
    put(8'hE8, 1'h1);
    put(8'hE2, 1'h1);
    put(8'h84, 1'h1);
    put(8'h71, 1'h1);
    put(8'hAA, 1'h1);
    chk("addr", 8'h04, {2'h0, ramWrAddr});
    chk("data", 8'hAA, ramWrData);
    put(8'h5A, 1'h1);
    chk("addr", 8'h0C, {2'h0, ramWrAddr});
    chk("cfg", 8'h91, cfg);
    open(8'h70, 1'h1);
    put(8'h65, 1'h1);
    put(8'h33, 1'h0);
    chk("writes", 8'h02, wrCount);
    chk("ptr", 8'h1C, {2'h0, dataPointer});
    open(8'h70, 1'h1);
    put(8'hA6, 1'h1);
    put(8'h62, 1'h1);
    put(8'h77, 1'h1);
    chk("addr", 8'h26, {2'h0, ramWrAddr});
    chk("ptr", 8'h00, {2'h0, dataPointer});
    chk("sub", 8'h03, {5'h0, subaddrCount});
    mst.stopCond;
    chk("busy", 8'h00, {7'h0, busActive});
    open(8'h70, 1'h1);
    mst.sendBits(8'h40, 4, a);
    open(8'h70, 1'h1);
    mst.stopCond;
    chk("cfg", 8'h91, cfg);
    chk("writes", 8'h03, wrCount);
    // Every drive mode with bank select, alternate blink and pointer step
    for (int i = 0; i < 4; i++)
    begin
      open(8'h70, 1'h1);
      put(8'hC9, 1'h1);
      put(8'hF8, 1'h1);
      put(8'hC8 | 8'((i + 1) % 4), 1'h1);
      put(8'hFB, 1'h1);
      put(8'hF7, 1'h1);
      put(8'hE2, 1'h1);
      put(8'h00, 1'h1);
      put(8'h55, 1'h1);
      mst.stopCond;
      chk("mode", 8'((i + 1) % 4), {6'h0, driveModeHi, driveModeLo});
      chk("banks", i < 2 ? 8'h03 : 8'h00, {6'h0, inputBank, outputBank});
      chk("alt", i < 2 ? 8'h01 : 8'h00, {7'h0, blinkAltBank});
      chk("ptr", {2'h0, stepTab[i]}, {2'h0, dataPointer});
      chk("wbank", i < 2 ? 8'h01 : 8'h00, {7'h0, ramWrBank});
      chk("data", 8'h55, ramWrData);
    end
    strap = 1'h1;
    open(8'h70, 1'h0);
    open(8'h72, 1'h1);
    put(8'h4D, 1'h1);
    mst.stopCond;
    chk("cfg", 8'hD3, cfg);
    stop_test;
  end
endmodule
